// ===== hw/ext_bus_pkg.sv
`default_nettype none

package ext_bus_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] BUS_CONTROL_INDEX = 16'hFFC6;
  localparam logic [15:0] WAIT_CONTROL_INDEX = 16'hFFC7;
  localparam logic [15:0] SYSTEM_CONTROL_INDEX = 16'hFFC8;
  localparam logic [15:0] STATUS_INDEX = 16'hFFC9;

  // Reset values of the registers.
  localparam logic [7:0] BUS_CONTROL_RESET = 8'hD7;
  localparam logic [7:0] WAIT_CONTROL_RESET = 8'h33;
  localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h02;

  // Field positions in bus_control_reg.
  localparam int IO_RANGE_LO_POS = 0;
  localparam int BURST_STATES_POS = 4;
  localparam int BURST_ROM_POS = 5;

  // Field positions in the wait control register.
  localparam int WAIT_COUNT_LO_POS = 0;
  localparam int WAIT_MODE_LO_POS = 2;
  localparam int ACCESS_STATE_POS = 4;
  localparam int BUS_WIDTH_POS = 5;
  localparam logic [7:0] WAIT_CONTROL_MASK = 8'h3F;

  // Field positions in system_control_reg.
  localparam int IO_SELECT_ENABLE_POS = 0;
  localparam int RAM_ENABLE_POS = 1;
  localparam logic [7:0] SYSTEM_CONTROL_MASK = 8'h03;

  // I/O select range: a fixed base and four selectable tops.
  localparam logic [15:0] IO_RANGE_BASE = 16'hF000;
  localparam logic [15:0] IO_RANGE_TOP_0 = 16'hF03F;
  localparam logic [15:0] IO_RANGE_TOP_1 = 16'hF0FF;
  localparam logic [15:0] IO_RANGE_TOP_2 = 16'hF3FF;
  localparam logic [15:0] IO_RANGE_TOP_3 = 16'hFE4F;
  localparam logic [7:0] ADVANCED_PAGE = 8'hFF;

  // Fixed cycle count of every internal access.
  localparam logic [1:0] INTERNAL_STATES = 2'h2;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Wait modes.
  typedef enum logic [1:0] {
    WAIT_PROGRAM = 2'h0,
    WAIT_DISABLED = 2'h1,
    WAIT_PIN = 2'h2,
    WAIT_AUTO = 2'h3
  } wait_mode_type;

  // Access sizes of the internal request.
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } size_type;

  // Bus cycle states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_T1 = 6'h02,
    ST_T2 = 6'h04,
    ST_TW = 6'h08,
    ST_T3 = 6'h10,
    ST_INT = 6'h20
  } bus_state_type;

  // External bus pin outputs.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic data_oe;
    logic read_strobe_n;
    logic upper_write_strobe_n;
    logic strobe_pin_n;
  } ext_out_type;

  // Whole state of the controller.
  typedef struct packed {
    logic aw_hold;
    logic [17:0] aw_addr;
    logic w_hold;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] bus_control;
    logic [7:0] wait_control;
    logic [7:0] system_control;
    bus_state_type state;
    logic [23:0] addr;
    logic write;
    logic three_state;
    logic [31:0] wdata;
    logic [1:0] beats_left;
    logic [1:0] wait_left;
    logic [31:0] rd_acc;
    logic resp_valid;
    logic [31:0] resp_rdata;
  } state_type;

endpackage

`default_nettype wire

// ===== hw/ext_bus_ctrl.sv
// Our own choices: register access over AXI4-Lite and the register addresses.

`default_nettype none

module ext_bus_ctrl
  import ext_bus_pkg::*;
#(
  parameter logic [15:0] IOREG_LO = 16'hFE50,
  parameter logic [15:0] RAM_LO = 16'hE000,
  parameter logic [15:0] RAM_HI = 16'hEFFF,
  parameter logic [23:0] ROM_HI = 24'h00DFFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [17:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [17:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic expanded_mode,
  input wire logic rom_enabled_mode,
  input wire logic advanced_mode,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [23:0] req_addr,
  input wire logic req_write,
  input wire size_type req_size,
  input wire logic [31:0] req_wdata,
  output logic resp_valid,
  output logic [31:0] resp_rdata,
  output logic internal_access,
  output ext_out_type ext_out,
  input wire logic [7:0] ext_data_in,
  input wire logic wait_n
);

  state_type cur_reg;  // All registered state.
  state_type cur_next;  // Next value of the state.

  // Decode helpers, all combinational.
  logic is_internal;  // Request hits on-chip memory or registers.
  logic is_external;  // Request goes to the external bus.
  logic in_window;  // Address lies in the advanced-mode window.
  logic [15:0] io_top;  // Top of the I/O select range.
  logic io_hit;  // Current cycle lies in the I/O select range.
  logic ext_active;  // An external bus state is in progress.
  logic [1:0] wc;  // Programmed wait count.
  wait_mode_type wmode;  // Selected wait mode.
  logic [7:0] rd_value;  // Register read data.
  logic rd_ok;  // Read address is mapped.

  // Address decoding of the incoming request.
  always_comb begin
    in_window = (req_addr[23:16] == ADVANCED_PAGE) &&
                (req_addr[15:0] >= IO_RANGE_BASE) && (req_addr[15:0] <= IO_RANGE_TOP_3);
    is_internal = (req_addr[15:0] >= IOREG_LO) ||
                  (cur_reg.system_control[RAM_ENABLE_POS] &&
                   req_addr[15:0] >= RAM_LO && req_addr[15:0] <= RAM_HI) ||
                  (rom_enabled_mode && req_addr <= ROM_HI);
    // In single-chip mode nothing is external.
    is_external = expanded_mode && !is_internal &&
                  (!advanced_mode || in_window);
  end

  // The I/O select range and the wait settings.
  always_comb begin
    unique case (cur_reg.bus_control[IO_RANGE_LO_POS +: 2])
      2'h0: io_top = IO_RANGE_TOP_0;
      2'h1: io_top = IO_RANGE_TOP_1;
      2'h2: io_top = IO_RANGE_TOP_2;
      2'h3: io_top = IO_RANGE_TOP_3;
    endcase
    ext_active = (cur_reg.state == ST_T1) || (cur_reg.state == ST_T2) ||
                 (cur_reg.state == ST_TW) || (cur_reg.state == ST_T3);
    io_hit = ext_active && (cur_reg.addr[15:0] >= IO_RANGE_BASE) &&
             (cur_reg.addr[15:0] <= io_top) &&
             (!advanced_mode || cur_reg.addr[23:16] == ADVANCED_PAGE);
    wc = cur_reg.wait_control[WAIT_COUNT_LO_POS +: 2];
    wmode = wait_mode_type'(cur_reg.wait_control[WAIT_MODE_LO_POS +: 2]);
  end

  // Register read mux.
  always_comb begin
    rd_ok = 1'b1;
    rd_value = 8'h00;
    if (araddr[1:0] != 2'h0) begin
      rd_ok = 1'b0;
    end else if (araddr[17:2] == BUS_CONTROL_INDEX) begin
      rd_value = cur_reg.bus_control;
    end else if (araddr[17:2] == WAIT_CONTROL_INDEX) begin
      rd_value = cur_reg.wait_control;
    end else if (araddr[17:2] == SYSTEM_CONTROL_INDEX) begin
      rd_value = cur_reg.system_control;
    end else if (araddr[17:2] == STATUS_INDEX) begin
      // Busy flag and the access-state selection latched when the last request was taken.
      rd_value = {6'h00, cur_reg.three_state, cur_reg.state != ST_IDLE};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Next-state logic for the register slave and the bus cycle engine.
  always_comb begin
    cur_next = cur_reg;
    cur_next.resp_valid = 1'b0;
    // Address and data are caught in either order.
    if (awvalid && awready) begin
      cur_next.aw_hold = 1'b1;
      cur_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      cur_next.w_hold = 1'b1;
      cur_next.w_data = wdata[7:0];
      cur_next.w_lane0 = wstrb[0];
    end
    if (bvalid && bready) begin
      cur_next.bvalid = 1'b0;
    end
    // Both halves present: perform the write and answer.
    if (cur_reg.aw_hold && cur_reg.w_hold && !cur_reg.bvalid) begin
      cur_next.aw_hold = 1'b0;
      cur_next.w_hold = 1'b0;
      cur_next.bvalid = 1'b1;
      cur_next.bresp = RESP_OKAY;
      if (cur_reg.aw_addr[1:0] != 2'h0) begin
        cur_next.bresp = RESP_SLVERR;
      end else if (cur_reg.aw_addr[17:2] == BUS_CONTROL_INDEX) begin
        if (cur_reg.w_lane0) begin
          cur_next.bus_control = cur_reg.w_data;
        end
      end else if (cur_reg.aw_addr[17:2] == WAIT_CONTROL_INDEX) begin
        if (cur_reg.w_lane0) begin
          // The width bit stays at its 8-bit setting.
          cur_next.wait_control = (cur_reg.w_data & WAIT_CONTROL_MASK) |
                                  (8'h01 << BUS_WIDTH_POS);
        end
      end else if (cur_reg.aw_addr[17:2] == SYSTEM_CONTROL_INDEX) begin
        if (cur_reg.w_lane0) begin
          cur_next.system_control = cur_reg.w_data & SYSTEM_CONTROL_MASK;
        end
      end else if (cur_reg.aw_addr[17:2] != STATUS_INDEX) begin
        cur_next.bresp = RESP_SLVERR;
      end
    end
    // Reads answer in the cycle after the address is taken.
    if (rvalid && rready) begin
      cur_next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      cur_next.rvalid = 1'b1;
      cur_next.rdata = {24'h000000, rd_value};
      cur_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Bus cycle engine.
    unique case (cur_reg.state)
      ST_IDLE: begin
        if (req_valid) begin
          cur_next.addr = req_addr;
          cur_next.write = req_write;
          cur_next.wdata = req_wdata;
          cur_next.rd_acc = 32'h00000000;
          // Wider accesses become byte beats.
          unique case (req_size)
            SIZE_WORD: cur_next.beats_left = 2'h1;
            SIZE_LONG: cur_next.beats_left = 2'h3;
            default: cur_next.beats_left = 2'h0;
          endcase
          // With the burst bit set, every access takes its count from the burst states bit.
          cur_next.three_state = cur_reg.bus_control[BURST_ROM_POS] ?
                                 cur_reg.bus_control[BURST_STATES_POS] :
                                 cur_reg.wait_control[ACCESS_STATE_POS];
          if (is_external) begin
            cur_next.state = ST_T1;
          end else begin
            cur_next.wait_left = INTERNAL_STATES - 2'h1;
            cur_next.state = ST_INT;
          end
        end
      end
      ST_INT: begin
        // Internal accesses finish after a fixed count; no strobe or data driver goes active.
        if (cur_reg.wait_left != 2'h0) begin
          cur_next.wait_left = cur_reg.wait_left - 2'h1;
        end else begin
          cur_next.state = ST_IDLE;
          cur_next.resp_valid = 1'b1;
          cur_next.resp_rdata = 32'h00000000;
        end
      end
      ST_T1: begin
        cur_next.state = ST_T2;
      end
      ST_T2: begin
        if (!cur_reg.three_state) begin
          cur_next.state = ST_T1;
        end else begin
          cur_next.state = ST_T3;
          // Waits go between the second and third states.
          unique case (wmode)
            WAIT_DISABLED: cur_next.state = ST_T3;
            WAIT_AUTO: begin
              if (!wait_n && wc != 2'h0) begin
                cur_next.state = ST_TW;
              end
            end
            WAIT_PIN: begin
              if (wc != 2'h0 || !wait_n) begin
                cur_next.state = ST_TW;
              end
            end
            WAIT_PROGRAM: begin
              if (wc != 2'h0) begin
                cur_next.state = ST_TW;
              end
            end
          endcase
          cur_next.wait_left = (wc == 2'h0) ? 2'h0 : wc - 2'h1;
        end
      end
      ST_TW: begin
        if (cur_reg.wait_left != 2'h0) begin
          cur_next.wait_left = cur_reg.wait_left - 2'h1;
        end else if (!(wmode == WAIT_PIN && !wait_n)) begin
          cur_next.state = ST_T3;
        end
      end
      ST_T3: begin
        cur_next.state = ST_T1;
      end
      default: begin
        cur_next.state = ST_IDLE;
      end
    endcase

    // Close a beat at the end of the last state of a byte cycle.
    if ((cur_reg.state == ST_T3) || (cur_reg.state == ST_T2 && !cur_reg.three_state)) begin
      cur_next.rd_acc = {cur_reg.rd_acc[23:0], ext_data_in};
      if (cur_reg.beats_left == 2'h0) begin
        cur_next.state = ST_IDLE;
        cur_next.resp_valid = 1'b1;
        cur_next.resp_rdata = cur_reg.write ? 32'h00000000 :
                              {cur_reg.rd_acc[23:0], ext_data_in};
      end else begin
        cur_next.beats_left = cur_reg.beats_left - 2'h1;
        cur_next.addr = cur_reg.addr + 24'h000001;
      end
    end
  end

  // State register; reset gives three-state basic interface.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_reg <= '0;
      cur_reg.state <= ST_IDLE;
      cur_reg.bus_control <= BUS_CONTROL_RESET;
      cur_reg.wait_control <= WAIT_CONTROL_RESET;
      cur_reg.system_control <= SYSTEM_CONTROL_RESET;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Bus slave handshakes; one write and one read outstanding.
  assign awready = !cur_reg.aw_hold && !cur_reg.bvalid;
  assign wready = !cur_reg.w_hold && !cur_reg.bvalid;
  assign bvalid = cur_reg.bvalid;
  assign bresp = cur_reg.bresp;
  assign arready = !cur_reg.rvalid;
  assign rvalid = cur_reg.rvalid;
  assign rdata = cur_reg.rdata;
  assign rresp = cur_reg.rresp;

  // Internal request port.
  assign req_ready = (cur_reg.state == ST_IDLE);
  assign resp_valid = cur_reg.resp_valid;
  assign resp_rdata = cur_reg.resp_rdata;
  assign internal_access = (cur_reg.state == ST_INT);

  // Pin outputs decoded from registered state and the advanced_mode input.
  always_comb begin
    ext_out.addr = cur_reg.addr[15:0];
    // Byte order is high first; the last beat always takes wdata[7:0].
    unique case (cur_reg.beats_left)
      2'h3: ext_out.data = cur_reg.wdata[31:24];
      2'h2: ext_out.data = cur_reg.wdata[23:16];
      2'h1: ext_out.data = cur_reg.wdata[15:8];
      2'h0: ext_out.data = cur_reg.wdata[7:0];
    endcase
    ext_out.data_oe = ext_active && cur_reg.write;
    // A read strobe is only issued for reads, a write strobe only for writes.
    ext_out.read_strobe_n = !(ext_active && !cur_reg.write);
    ext_out.upper_write_strobe_n = !(cur_reg.write && cur_reg.state != ST_T1 &&
                                     ext_active);
    // The shared pin is the address strobe until the enable bit is set.
    if (cur_reg.system_control[IO_SELECT_ENABLE_POS]) begin
      ext_out.strobe_pin_n = !io_hit;
    end else begin
      ext_out.strobe_pin_n = !ext_active;
    end
  end

  // The protection inputs carry no meaning here.
  logic unused_ok;
  assign unused_ok = ^{awprot, arprot, wdata[31:8], wstrb[3:1]};

endmodule

`default_nettype wire

// ===== tb/ext_bus_assertions.sv
`default_nettype none

module ext_bus_checker
  import ext_bus_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic internal_access,
  input wire ext_out_type ext_out
);
  // All checks share the one clock; reset masks them.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Read and write strobes never overlap.
  a_strobes_exclusive: assert property (!(!ext_out.read_strobe_n && !ext_out.upper_write_strobe_n))
    else $error("read and write strobes low together");
  // Internal accesses leave the read and write strobes and the data drivers off.
  a_internal_quiet: assert property (internal_access |-> ext_out.read_strobe_n
    && ext_out.upper_write_strobe_n && !ext_out.data_oe)
    else $error("external pins active during internal access");
  // An internal access answers within its fixed count.
  a_internal_answer: assert property ($rose(internal_access) |-> ##[1:3] resp_valid)
    else $error("internal access answer late");
  // A write strobe always comes with driven data.
  a_write_drives: assert property (!ext_out.upper_write_strobe_n |-> ext_out.data_oe)
    else $error("write strobe without data drive");
  // During a read the data pins are released for the far side.
  a_read_released: assert property (!ext_out.read_strobe_n |-> !ext_out.data_oe)
    else $error("data driven during read");
  // A taken request makes the engine busy on the next cycle.
  a_busy_refuses: assert property (req_valid && req_ready |=> !req_ready)
    else $error("request port still ready after take");
  // The answer is a single-cycle pulse.
  a_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("answer pulse too long");
  // Address and data hold while a write strobe stays low.
  a_write_stable: assert property (!ext_out.upper_write_strobe_n
    && $past(!ext_out.upper_write_strobe_n) |-> $stable(ext_out.addr) && $stable(ext_out.data))
    else $error("write address or data moved");

  c_ext_read: cover property ($fell(ext_out.read_strobe_n));
  c_ext_write: cover property (!ext_out.upper_write_strobe_n);
  c_internal: cover property (internal_access);
  c_strobe_pin: cover property (!ext_out.strobe_pin_n);
endmodule

bind ext_bus_ctrl ext_bus_checker ext_bus_checker_i (.aclk(aclk), .aresetn(aresetn),
  .req_valid(req_valid), .req_ready(req_ready), .resp_valid(resp_valid),
  .internal_access(internal_access), .ext_out(ext_out));

`default_nettype wire

// ===== tb/ext_mem_model.sv
`default_nettype none

module ext_mem_model
  import ext_bus_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire ext_out_type ext_out,
  input wire logic [2:0] stall_len,
  output logic [7:0] ext_data_in,
  output logic wait_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535]; // Byte memory on the 8-bit bus.
  logic [7:0] last_reg; // Last value shown, inverted when idle.
  logic [2:0] cnt_reg; // Cycles since the access began, held at 7.
  logic active; // A beat is on the bus.

  // Known pattern so reads before any write are checkable.
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
  end

  assign active = !ext_out.read_strobe_n || ext_out.data_oe;
  // Released bus shows the inverse of the last value, so no stale match is possible.
  assign ext_data_in = !ext_out.read_strobe_n ? mem[ext_out.addr] : ~last_reg;
  // Wait is pulled high and held low for the first stall_len cycles of an access; the count does not restart between beats.
  assign wait_n = !(active && cnt_reg < stall_len);

  // Access cycle counter and byte store on the single write strobe.
  always_ff @(posedge aclk) begin
    last_reg <= ext_data_in;
    if (!aresetn || !active) cnt_reg <= 3'h0;
    else if (cnt_reg != 3'h7) cnt_reg <= cnt_reg + 3'h1;
    if (!ext_out.upper_write_strobe_n && ext_out.data_oe) mem[ext_out.addr] <= ext_out.data;
  end
endmodule

`default_nettype wire

// ===== tb/external_bus_space_config_tb_top.sv
`default_nettype none

module external_bus_space_config_tb_top
  import ext_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, req_valid, req_write;
  logic awready, wready, bvalid, arready, rvalid, req_ready, resp_valid, internal_access, wait_n;
  logic expanded_mode, rom_enabled_mode, advanced_mode, ram_en, ios_en;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, req_wdata, resp_rdata;
  logic [1:0] bresp, rresp, rng;
  logic [2:0] awprot, arprot, stall_len;
  logic [3:0] wstrb;
  logic [23:0] req_addr;
  logic [7:0] ext_data_in;
  size_type req_size;
  ext_out_type ext_out;
  logic [7:0] shadow [logic [15:0]]; // Bytes written to the far side.
  int num_errors, samples_checked, seed;

  ext_bus_ctrl ext_bus_ctrl_i (.*);
  ext_mem_model ext_mem_model_i (.*);

  // Free-running 40 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One AXI write; address and data are released as each is taken.
  task automatic axi_wr(input logic [17:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= {24'h0, d}; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  // One AXI read; rready stands from the start and data is taken at the rvalid edge.
  task automatic axi_rd(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask

  function automatic logic is_ext(input logic [23:0] a);
    if (!expanded_mode || a[15:0] >= 16'hFE50) return 1'b0;
    if (advanced_mode && (a[23:16] != 8'hFF || a[15:0] < 16'hF000)) return 1'b0;
    if (a[15:0] >= 16'hE000 && a[15:0] <= 16'hEFFF && ram_en) return 1'b0;
    return !(a[15:0] <= 16'hDFFF && rom_enabled_mode);
  endfunction

  function automatic logic in_io(input logic [15:0] a);
    return a >= 16'hF000 && a <= (rng == 0 ? 16'hF03F : rng == 1 ? 16'hF0FF :
      rng == 2 ? 16'hF3FF : 16'hFE4F);
  endfunction

  function automatic int exp_lat(input logic e, input logic [7:0] wc, input int n, input int st);
    int waits;
    if (!e) return 3;
    if (!wc[4]) return 2 * n + 1;
    case (wc[3:2])
      2'h0: waits = wc[1:0];
      2'h1: waits = 0;
      2'h2: waits = st > 1 ? st - 1 : wc[1:0];
      default: waits = st > 1 ? wc[1:0] : 0;
    endcase
    return n * (3 + waits) + 1;
  endfunction

  function automatic logic [7:0] mb(input logic [15:0] a);
    return shadow.exists(a) ? shadow[a] : a[7:0] ^ a[15:8];
  endfunction

  // One request; counts edges to the answer and notes which strobes fell.
  task automatic run_req(input logic [23:0] a, input logic w, input logic [7:0] wc);
    logic [31:0] wd, er;
    logic rdn, wrn, pinn, e;
    int lat, n;
    wd = $random(seed);
    n = 1 << req_size;
    @(posedge aclk);
    req_valid <= 1'b1; req_addr <= a; req_write <= w; req_wdata <= wd;
    do @(posedge aclk); while (!req_ready);
    req_valid <= 1'b0;
    lat = 0; rdn = 1'b1; wrn = 1'b1; pinn = 1'b1;
    do begin
      @(posedge aclk);
      lat++;
      rdn &= ext_out.read_strobe_n;
      wrn &= ext_out.upper_write_strobe_n;
      pinn &= ext_out.strobe_pin_n;
    end while (!resp_valid && lat < 60);
    e = is_ext(a);
    er = 32'h0;
    for (int i = 0; i < n; i++) begin
      if (e && w) shadow[a[15:0] + 16'(i)] = wd[8 * (n - 1 - i) +: 8];
      if (e && !w) er = {er[23:0], mb(a[15:0] + 16'(i))};
    end
    chk(32'(lat), 32'(exp_lat(e, wc, n, stall_len)));
    chk(resp_rdata, er);
    chk({rdn, wrn, pinn}, {!(e && !w), !(e && w), !(e && (!ios_en || in_io(a[15:0])))});
  endtask

  // Hang guard.
  initial begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    wrap_up();
  end

  // Main sequence: reset defaults, then random configurations and requests.
  initial begin
    logic [31:0] rv;
    logic [7:0] wc;
    logic [1:0] r;
    logic [15:0] a16;
    seed = 3160;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, req_valid, req_write} = '0;
    {awaddr, araddr, wdata, req_wdata, req_addr, awprot, arprot} = '0;
    {expanded_mode, rom_enabled_mode, advanced_mode, ram_en, ios_en, rng} = 6'h23;
    wstrb = 4'hF; req_size = SIZE_BYTE; stall_len = 3'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    run_req(24'h00F010, 1'b0, WAIT_CONTROL_RESET);
    axi_rd(18'h3FF18, 32'hD7, RESP_OKAY);
    axi_rd(18'h3FF1C, 32'h33, RESP_OKAY);
    axi_rd(18'h3FF20, 32'h02, RESP_OKAY);
    axi_rd(18'h3FF24, 32'h02, RESP_OKAY);
    axi_rd(18'h00100, 32'h0, RESP_SLVERR);
    axi_wr(18'h3FF1C, 8'h13, r);
    axi_rd(18'h3FF1C, 32'h33, RESP_OKAY);
    for (int i = 0; i < 60; i++) begin
      rv = $random(seed);
      wc = {3'h1, rv[0] | rv[1], rv[5:2]};
      req_size <= size_type'(rv[7:6] == 2'h3 ? 2'h0 : rv[7:6]);
      stall_len <= rv[7:6] == 2'h0 || rv[7:6] == 2'h3 ? rv[10:8] : 3'h0;
      if (wc[3:2] == 2'h2 && rv[10:9] != 2'h0) wc[1:0] = 2'h0;
      expanded_mode <= rv[11] | rv[12];
      rom_enabled_mode <= rv[13];
      advanced_mode <= rv[14];
      {ram_en, ios_en, rng} = rv[18:15];
      case (rv[21:20])
        2'h0: a16 = (advanced_mode && !rv[13]) ? {4'hF, rv[31:22], 2'h0} : {4'h1, rv[31:22], 2'h0};
        2'h1: a16 = {4'hE, rv[31:22], 2'h0};
        2'h2: a16 = {4'hF, rv[31:22], 2'h0};
        default: a16 = {8'hFF, rv[29:22]};
      endcase
      axi_wr(18'h3FF1C, wc, r);
      axi_wr(18'h3FF20, {6'h0, ram_en, ios_en}, r);
      axi_wr(18'h3FF18, {6'h35, rng}, r);
      chk(32'(r), 32'(RESP_OKAY));
      axi_rd(18'h3FF1C, {24'h0, wc}, RESP_OKAY);
      run_req({(rv[14] && a16 >= 16'hE000) ? 8'hFF : 8'h00, a16}, rv[19], wc);
    end
    wrap_up();
  end
endmodule

`default_nettype wire
